// ==== hw/hbi_cfg.svh ====
// Constants for the host bus interface: commands, fixed addresses, timing.
// Assumes a single 10 MHz system clock.
`ifndef HBI_CFG_SVH
`define HBI_CFG_SVH
`define HBI_CMD_WRITE      8'h02
`define HBI_CMD_READ       8'h03
`define HBI_CMD_RD_STATUS  8'h05
`define HBI_CMD_WR_COMMAND 8'h07
`define HBI_ADDR_STATUS    8'hf0
`define HBI_ADDR_COMMAND   8'hf4
`define HBI_CLK_PERIOD_NS  100
`define HBI_RESET_MIN_NS   250
`define HBI_RESET_MIN_CYC  ((`HBI_RESET_MIN_NS + `HBI_CLK_PERIOD_NS - 1) / `HBI_CLK_PERIOD_NS)
`endif

// ==== hw/hbi_pkg.sv ====
// Types shared by the host bus interface files.
// Assumes nothing of its surroundings.
package hbi_pkg;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } hbi_req_s;
    typedef enum logic [3:0] {
        HBI_S_CMD  = 4'h1,
        HBI_S_ADDR = 4'h2,
        HBI_S_DATA = 4'h4,
        HBI_S_SKIP = 4'h8
    } hbi_spi_e;
endpackage

// ==== hw/hbi_edge.sv ====
// Edge detector for a pin that is synchronous to the system clock.
// Assumes the input is already aligned to CLK_I.
module hbi_edge (
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic pin_i,
    output logic      rise_o,
    output logic      fall_o
);
    logic prev_q;
    logic prev_d;
    logic primed_q;
    logic primed_d;
    always_comb begin
        prev_d   = pin_i;
        primed_d = 1'b1;
    end
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            prev_q   <= 1'b0;
            primed_q <= 1'b0;
        end else begin
            prev_q   <= prev_d;
            primed_q <= primed_d;
        end
    end
    // No edge until the history holds a real sample: a pin idling high would look like a rise after reset
    assign rise_o = primed_q & pin_i & ~prev_q;
    assign fall_o = primed_q & ~pin_i & prev_q;
endmodule

// ==== hw/hbi_host_port.sv ====
// Host access port: multiplexed parallel bus (two strobe styles) or mode-0 serial.
// Assumes pins synchronous to CLK_I and a register file that answers reads combinationally.
`include "hbi_cfg.svh"

// What this block does
// - Serial select low: parallel, style pin picks protocol
// - Serial select high: mode-0 serial, style ignored
// - Parallel bus carries address then data
// - Address captured at latch strobe falling edge
// - Separate strobes: write at strobe rising edge
// - Separate strobes: drive on read low
// - Enable style: write data captured at enable fall
// - Enable style: read driven while enable high
// - Serial reuses latch, select, bit0, bit1 pins
// - Sample input on rise, shift output on fall
// - Serial output released when select rises
// - Frame: command, optional address, then data
// - Commands 02h write, 03h read, addressed
// - Command 05h reads from address 240
// - Command 07h writes from address 244
// - Address increments after every data byte
// - Chip select active low gates everything
// - Reset holds the port in reset state
module hbi_host_port (
    input  wire logic                 CLK_I,
    input  wire logic                 RESET_I,
    input  wire logic                 SERIAL_PORT_SELECT_I,
    input  wire logic                 STROBE_STYLE_SELECT_I,
    input  wire logic                 CHIP_SELECT_N_I,
    input  wire logic                 ADDR_LATCH_I,
    input  wire logic                 WRITE_OR_ENABLE_STROBE_I,
    input  wire logic                 READ_OR_DIRECTION_SELECT_I,
    input  wire logic [7:0]           BUS_I,
    output logic      [7:0]           BUS_O,
    output logic      [7:0]           BUS_OE_O,
    input  wire logic [7:0]           REG_RDATA_I,
    output logic      [7:0]           REG_RADDR_O,
    output hbi_pkg::hbi_req_s         REG_REQ_O
);
    logic       ale_rise;
    logic       ale_fall;
    logic       wre_rise;
    logic       wre_fall;
    logic       sel;
    logic       spi;
    logic       sep;

    hbi_edge u_ale (
        .clk_i  (CLK_I),
        .reset_i(RESET_I),
        .pin_i  (ADDR_LATCH_I),
        .rise_o (ale_rise),
        .fall_o (ale_fall)
    );
    hbi_edge u_wre (
        .clk_i  (CLK_I),
        .reset_i(RESET_I),
        .pin_i  (WRITE_OR_ENABLE_STROBE_I),
        .rise_o (wre_rise),
        .fall_o (wre_fall)
    );

    assign sel = ~CHIP_SELECT_N_I;
    assign spi = SERIAL_PORT_SELECT_I;
    assign sep = STROBE_STYLE_SELECT_I;

    // Shared state for both modes
    logic [7:0]          addr_q, addr_d;
    logic [7:0]          sh_q, sh_d;
    logic [2:0]          cnt_q, cnt_d;
    logic                so_q, so_d;
    logic                par_drive;
    hbi_pkg::hbi_spi_e   st_q, st_d;
    logic                is_rd_q, is_rd_d;
    hbi_pkg::hbi_req_s   req_q, req_d;
    logic [7:0]          bus_q, bus_d;
    logic [7:0]          oe_q, oe_d;

    always_comb begin
        logic [7:0] nb;
        nb      = {sh_q[6:0], BUS_I[0]};
        addr_d  = addr_q;
        sh_d    = sh_q;
        cnt_d   = cnt_q;
        so_d    = so_q;
        par_drive = 1'b0;
        st_d    = st_q;
        is_rd_d = is_rd_q;
        req_d   = '0;
        if (!sel) begin
            // Frame ends: serial state rewinds for the next command
            st_d  = hbi_pkg::HBI_S_CMD;
            cnt_d = 3'h0;
        end else if (!spi) begin
            if (ale_fall) begin
                addr_d = BUS_I;
            end
            if (sep) begin
                par_drive = ~READ_OR_DIRECTION_SELECT_I;
                if (wre_rise) begin
                    req_d.wr    = 1'b1;
                    req_d.addr  = addr_q;
                    req_d.wdata = BUS_I;
                end
            end else begin
                par_drive = WRITE_OR_ENABLE_STROBE_I & READ_OR_DIRECTION_SELECT_I;
                if (wre_fall && !READ_OR_DIRECTION_SELECT_I) begin
                    req_d.wr    = 1'b1;
                    req_d.addr  = addr_q;
                    req_d.wdata = BUS_I;
                end
            end
        end else begin
            if (ale_rise) begin
                sh_d  = nb;
                cnt_d = cnt_q + 3'h1;
                if (cnt_q == 3'h7) begin
                    case (st_q)
                        hbi_pkg::HBI_S_CMD: begin
                            case (nb)
                                `HBI_CMD_WRITE: begin
                                    is_rd_d = 1'b0;
                                    st_d    = hbi_pkg::HBI_S_ADDR;
                                end
                                `HBI_CMD_READ: begin
                                    is_rd_d = 1'b1;
                                    st_d    = hbi_pkg::HBI_S_ADDR;
                                end
                                `HBI_CMD_RD_STATUS: begin
                                    is_rd_d = 1'b1;
                                    addr_d  = `HBI_ADDR_STATUS;
                                    st_d    = hbi_pkg::HBI_S_DATA;
                                end
                                `HBI_CMD_WR_COMMAND: begin
                                    is_rd_d = 1'b0;
                                    addr_d  = `HBI_ADDR_COMMAND;
                                    st_d    = hbi_pkg::HBI_S_DATA;
                                end
                                default: st_d = hbi_pkg::HBI_S_SKIP;
                            endcase
                        end
                        hbi_pkg::HBI_S_ADDR: begin
                            addr_d = nb;
                            st_d   = hbi_pkg::HBI_S_DATA;
                        end
                        hbi_pkg::HBI_S_DATA: begin
                            if (!is_rd_q) begin
                                req_d.wr    = 1'b1;
                                req_d.addr  = addr_q;
                                req_d.wdata = nb;
                            end else begin
                                req_d.rd   = 1'b1;
                                req_d.addr = addr_q;
                            end
                            addr_d = addr_q + 8'h01;
                        end
                        default: st_d = hbi_pkg::HBI_S_SKIP;
                    endcase
                end
            end
            if (ale_fall) begin
                // Load the next byte at the falling edge that ends the byte before a read data byte
                if (cnt_q == 3'h0 && st_q == hbi_pkg::HBI_S_DATA && is_rd_q) begin
                    sh_d = REG_RDATA_I;
                    so_d = REG_RDATA_I[7];
                end else begin
                    so_d = sh_q[7];
                end
            end
        end
    end

    // Read address mirrors the port's current pointer
    assign REG_RADDR_O = addr_q;

    always_comb begin
        bus_d = 8'h00;
        oe_d  = 8'h00;
        if (sel && spi) begin
            bus_d[1] = so_d;
            oe_d[1]  = (st_d == hbi_pkg::HBI_S_DATA) && is_rd_d;
        end else if (sel && par_drive) begin
            bus_d = REG_RDATA_I;
            oe_d  = 8'hff;
        end
    end

    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            addr_q  <= 8'h00;
            sh_q    <= 8'h00;
            cnt_q   <= 3'h0;
            so_q    <= 1'b0;
            st_q    <= hbi_pkg::HBI_S_CMD;
            is_rd_q <= 1'b0;
            req_q   <= '0;
            bus_q   <= 8'h00;
            oe_q    <= 8'h00;
        end else begin
            addr_q  <= addr_d;
            sh_q    <= sh_d;
            cnt_q   <= cnt_d;
            so_q    <= so_d;
            st_q    <= st_d;
            is_rd_q <= is_rd_d;
            req_q   <= req_d;
            bus_q   <= bus_d;
            oe_q    <= oe_d;
        end
    end

    assign BUS_O     = bus_q;
    assign BUS_OE_O  = oe_q;
    assign REG_REQ_O = req_q;

    a_desel_quiet: assert property (@(posedge CLK_I) disable iff (RESET_I)
        CHIP_SELECT_N_I |=> (BUS_OE_O == 8'h00 && !REG_REQ_O.wr))
        else $error("drivers or write active while deselected");
    a_wr_strobe: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (!CHIP_SELECT_N_I && !spi && sep && wre_rise) |=> (REG_REQ_O.wr && REG_REQ_O.addr == $past(addr_q)))
        else $error("separate-strobe write not issued");
    a_en_write: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (!CHIP_SELECT_N_I && !spi && !sep && wre_fall && !READ_OR_DIRECTION_SELECT_I) |=> REG_REQ_O.wr)
        else $error("enable-style write not issued");
    a_sep_read: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (!CHIP_SELECT_N_I && !spi && sep && !READ_OR_DIRECTION_SELECT_I) |=> (BUS_OE_O == 8'hff))
        else $error("read byte not driven");
    a_en_read: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (!CHIP_SELECT_N_I && !spi && !sep && !WRITE_OR_ENABLE_STROBE_I) |=> (BUS_OE_O == 8'h00))
        else $error("bus driven while enable low");
    a_addr_latch: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (!CHIP_SELECT_N_I && !spi && ale_fall) |=> (addr_q == $past(BUS_I)))
        else $error("address not latched");
    a_so_release: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (spi && $rose(CHIP_SELECT_N_I)) |=> (BUS_OE_O[1] == 1'b0))
        else $error("serial output not released");
    a_fixed_status: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (sel && spi && ale_rise && st_q == hbi_pkg::HBI_S_CMD && cnt_q == 3'h7
         && {sh_q[6:0], BUS_I[0]} == `HBI_CMD_RD_STATUS) |=> (addr_q == `HBI_ADDR_STATUS))
        else $error("status read start address wrong");
    a_addr_incr: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (sel && spi && ale_rise && st_q == hbi_pkg::HBI_S_DATA && cnt_q == 3'h7)
        |=> (addr_q == $past(addr_q) + 8'h01))
        else $error("address not incremented");

    // Parallel data paths: the byte written or driven is the bus or register byte itself; then serial-mode pin and request checks
    a_sep_wdata: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (sel && !spi && sep && wre_rise) |=> (REG_REQ_O.wdata == $past(BUS_I)))
        else $error("separate-strobe write data wrong");
    a_en_wdata: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (sel && !spi && !sep && wre_fall && !READ_OR_DIRECTION_SELECT_I)
        |=> (REG_REQ_O.addr == $past(addr_q) && REG_REQ_O.wdata == $past(BUS_I)))
        else $error("enable-style write address or data wrong");
    a_en_rd_nowr: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (sel && !spi && !sep && wre_fall && READ_OR_DIRECTION_SELECT_I) |=> !REG_REQ_O.wr)
        else $error("write issued at end of enable-style read");
    a_sep_rd_data: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (sel && !spi && sep && !READ_OR_DIRECTION_SELECT_I) |=> (BUS_O == $past(REG_RDATA_I)))
        else $error("separate-strobe read byte wrong");
    a_sep_rd_release: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (sel && !spi && sep && READ_OR_DIRECTION_SELECT_I) |=> (BUS_OE_O == 8'h00))
        else $error("bus driven with read strobe high");
    a_en_rd_drive: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (sel && !spi && !sep && WRITE_OR_ENABLE_STROBE_I && READ_OR_DIRECTION_SELECT_I)
        |=> (BUS_OE_O == 8'hff && BUS_O == $past(REG_RDATA_I)))
        else $error("enable-style read byte not driven");
    a_mode_pins: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (sel && spi) |=> (BUS_OE_O[7:2] == 6'h00 && BUS_OE_O[0] == 1'b0))
        else $error("serial mode drives a parallel bus bit");
    a_spi_no_strobe: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (sel && spi && !ale_rise) |=> (!REG_REQ_O.wr && !REG_REQ_O.rd))
        else $error("serial request without serial clock");

    // Serial frame: bit count, command decode and data bytes
    a_cnt_step: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (sel && spi && ale_rise) |=> (cnt_q == $past(cnt_q) + 3'h1))
        else $error("serial bit count not advanced");
    a_si_sample: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (sel && spi && ale_rise) |=> (sh_q[0] == $past(BUS_I[0])))
        else $error("serial input bit not sampled");
    a_cmd_write: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (sel && spi && ale_rise && st_q == hbi_pkg::HBI_S_CMD && cnt_q == 3'h7
         && {sh_q[6:0], BUS_I[0]} == `HBI_CMD_WRITE) |=> (st_q == hbi_pkg::HBI_S_ADDR && !is_rd_q))
        else $error("write command not decoded");
    a_cmd_read: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (sel && spi && ale_rise && st_q == hbi_pkg::HBI_S_CMD && cnt_q == 3'h7
         && {sh_q[6:0], BUS_I[0]} == `HBI_CMD_READ) |=> (st_q == hbi_pkg::HBI_S_ADDR && is_rd_q))
        else $error("read command not decoded");
    a_fixed_command: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (sel && spi && ale_rise && st_q == hbi_pkg::HBI_S_CMD && cnt_q == 3'h7
         && {sh_q[6:0], BUS_I[0]} == `HBI_CMD_WR_COMMAND)
        |=> (addr_q == `HBI_ADDR_COMMAND && st_q == hbi_pkg::HBI_S_DATA && !is_rd_q))
        else $error("command write start address wrong");
    a_start_addr: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (sel && spi && ale_rise && st_q == hbi_pkg::HBI_S_ADDR && cnt_q == 3'h7)
        |=> (addr_q == $past({sh_q[6:0], BUS_I[0]}) && st_q == hbi_pkg::HBI_S_DATA))
        else $error("start address byte not taken");
    a_ser_write: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (sel && spi && ale_rise && st_q == hbi_pkg::HBI_S_DATA && cnt_q == 3'h7 && !is_rd_q)
        |=> (REG_REQ_O.wr && REG_REQ_O.addr == $past(addr_q) && REG_REQ_O.wdata == $past({sh_q[6:0], BUS_I[0]})))
        else $error("serial write byte not issued");
    a_ser_read: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (sel && spi && ale_rise && st_q == hbi_pkg::HBI_S_DATA && cnt_q == 3'h7 && is_rd_q)
        |=> (REG_REQ_O.rd && REG_REQ_O.addr == $past(addr_q)))
        else $error("serial read byte not marked");
    a_unknown_cmd: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (spi && st_q == hbi_pkg::HBI_S_SKIP) |=> (!REG_REQ_O.wr && !REG_REQ_O.rd))
        else $error("request inside a refused frame");

    // Serial output: changes only at a falling serial clock, held otherwise; deselect rewinds the serial state
    a_so_shift: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (sel && spi && ale_fall && !(cnt_q == 3'h0 && st_q == hbi_pkg::HBI_S_DATA && is_rd_q))
        |=> (BUS_O[1] == $past(sh_q[7])))
        else $error("serial output bit not shifted");
    a_so_load: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (sel && spi && ale_fall && cnt_q == 3'h0 && st_q == hbi_pkg::HBI_S_DATA && is_rd_q)
        |=> (BUS_O[1] == $past(REG_RDATA_I[7])))
        else $error("read byte not loaded on serial output");
    a_so_hold: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (sel && spi && !ale_fall) |=> (BUS_O[1] == $past(so_q)))
        else $error("serial output moved without falling clock");
    a_desel_rewind: assert property (@(posedge CLK_I) disable iff (RESET_I)
        CHIP_SELECT_N_I |=> (st_q == hbi_pkg::HBI_S_CMD && cnt_q == 3'h0))
        else $error("serial state not rewound while deselected");
endmodule

// ==== bench/hbi_host_model.sv ====
// Host bus master model: drives the parallel and serial pins of the host port.
// Assumes the testbench resolves the shared bus from oe_o and the port's own enables.
module hbi_host_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] bus_i,
    output logic            ser_o,
    output logic            style_o,
    output logic            cs_n_o,
    output logic            ale_o,
    output logic            wen_o,
    output logic            rdir_o,
    output logic [7:0]      dat_o,
    output logic [7:0]      oe_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {ser_o, style_o, ale_o, dat_o, oe_o} = '0;
        {cs_n_o, wen_o, rdir_o} = 3'h7;
    end
    // Pins always move 10 ns after a rising edge and hold for whole clocks
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #10;
    endtask
    task automatic par_access(input logic sty, input logic sel, input logic wr,
                              input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        ser_o = 1'b0;
        style_o = sty;
        wen_o = sty;
        rdir_o = sty | !wr;
        tick(2);
        cs_n_o = !sel;
        ale_o = 1'b1;
        dat_o = a;
        oe_o = 8'hff;
        tick(2);
        ale_o = 1'b0;
        tick(2);
        dat_o = d;
        oe_o = wr ? 8'hff : 8'h00;
        if (sty) begin
            wen_o = !wr;
            rdir_o = wr;
        end else begin
            wen_o = 1'b1;
        end
        tick(3);
        q = bus_i;
        wen_o = sty;
        rdir_o = sty | !wr;
        tick(2);
        oe_o = 8'h00;
        cs_n_o = 1'b1;
    endtask
    // Serial clock stands low outside frames; only the input bit is driven
    task automatic spi_frame(input logic sty, input logic [7:0] tx [4], input int n,
                             output logic [7:0] rx [4]);
        ser_o = 1'b1;
        style_o = sty;
        tick(2);
        cs_n_o = 1'b0;
        oe_o = 8'h01;
        tick(2);
        for (int i = 0; i < n; i++) begin
            for (int b = 7; b >= 0; b--) begin
                dat_o = {7'h00, tx[i][b]};
                tick(2);
                rx[i][b] = bus_i[1];
                ale_o = 1'b1;
                tick(2);
                ale_o = 1'b0;
            end
        end
        tick(2);
        cs_n_o = 1'b1;
        oe_o = 8'h00;
        tick(2);
    endtask
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench for the host port: parallel styles, deselect and serial commands.
// Assumes the host model above and a byte-wide register file held here.
`include "hbi_cfg.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic              ser, sty, cs_n, ale, wen, rdir;
    logic [7:0]        h_dat, h_oe, bus_o, bus_oe, bus_w, raddr, rdata;
    hbi_pkg::hbi_req_s req;
    logic [7:0]        mem [256];
    logic [15:0]       wlog [$];
    logic [7:0]        rlog [$];
    int                fail_count = 0;
    int                num_checks = 0;
    int                cycles = 0;
    always #50 clk = ~clk;
    // Undriven bus bits fall to the pin pull-down
    assign bus_w = (bus_oe & bus_o) | (~bus_oe & h_oe & h_dat);
    assign rdata = mem[raddr];
    hbi_host_model host (.clk_i(clk), .bus_i(bus_w), .ser_o(ser), .style_o(sty), .cs_n_o(cs_n),
        .ale_o(ale), .wen_o(wen), .rdir_o(rdir), .dat_o(h_dat), .oe_o(h_oe));
    hbi_host_port uut (.CLK_I(clk), .RESET_I(rst), .SERIAL_PORT_SELECT_I(ser),
        .STROBE_STYLE_SELECT_I(sty), .CHIP_SELECT_N_I(cs_n), .ADDR_LATCH_I(ale),
        .WRITE_OR_ENABLE_STROBE_I(wen), .READ_OR_DIRECTION_SELECT_I(rdir), .BUS_I(bus_w),
        .BUS_O(bus_o), .BUS_OE_O(bus_oe), .REG_RDATA_I(rdata), .REG_RADDR_O(raddr), .REG_REQ_O(req));
    always @(posedge clk) begin
        if (req.wr === 1'b1) begin
            wlog.push_back({req.addr, req.wdata});
        end
        if (req.rd === 1'b1) begin
            rlog.push_back(req.addr);
        end
        cycles++;
        if (cycles == 6000) begin
            fail_count++;
            finish_test();
        end
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_wr(input logic [7:0] a, input logic [7:0] d);
        logic [15:0] got;
        got = (wlog.size() > 0) ? wlog.pop_front() : 16'hxxxx;
        chk("register write", {a, d}, got);
    endtask
    task automatic chk_rd(input logic [7:0] a);
        logic [15:0] got;
        got = (rlog.size() > 0) ? {8'h00, rlog.pop_front()} : 16'hxxxx;
        chk("register read", {8'h00, a}, got);
    endtask
    task automatic t_parallel;
        logic [7:0] q;
        for (int s = 1; s >= 0; s--) begin
            host.par_access(s[0], 1'b1, 1'b1, 8'h5a + s[7:0], 8'ha5, q);
            chk_wr(8'h5a + s[7:0], 8'ha5);
            host.par_access(s[0], 1'b1, 1'b0, 8'h33 + s[7:0], 8'h00, q);
            chk("parallel read", {8'h00, mem[8'h33 + s]}, {8'h00, q});
            chk("bus released", 16'h0000, {8'h00, bus_oe});
        end
        chk("no stray write", 16'h0000, 16'(wlog.size()));
        $display("test parallel done");
    endtask
    task automatic t_deselect;
        logic [7:0] q;
        host.par_access(1'b1, 1'b0, 1'b1, 8'h10, 8'h77, q);
        host.par_access(1'b0, 1'b0, 1'b0, 8'h11, 8'h00, q);
        chk("deselected read", 16'h0000, {8'h00, q});
        chk("deselected writes", 16'h0000, 16'(wlog.size()));
        $display("test deselect done");
    endtask
    task automatic t_serial;
        logic [7:0] tx [4];
        logic [7:0] rx [4];
        tx = '{`HBI_CMD_WRITE, 8'h40, 8'h11, 8'h22};
        host.spi_frame(1'b0, tx, 4, rx);
        chk_wr(8'h40, 8'h11);
        chk_wr(8'h41, 8'h22);
        tx = '{`HBI_CMD_READ, 8'h7e, 8'h00, 8'h00};
        host.spi_frame(1'b1, tx, 4, rx);
        chk("serial read", {mem[8'h7e], mem[8'h7f]}, {rx[2], rx[3]});
        chk("serial out released", 16'h0000, {8'h00, bus_oe});
        chk_rd(8'h7e);
        chk_rd(8'h7f);
        tx = '{`HBI_CMD_RD_STATUS, 8'h00, 8'h00, 8'h00};
        host.spi_frame(1'b1, tx, 3, rx);
        chk("status read", {mem[240], mem[241]}, {rx[1], rx[2]});
        chk_rd(8'd240);
        chk_rd(8'd241);
        tx = '{`HBI_CMD_WR_COMMAND, 8'h5c, 8'h6d, 8'h00};
        host.spi_frame(1'b0, tx, 3, rx);
        chk_wr(8'd244, 8'h5c);
        chk_wr(8'd245, 8'h6d);
        tx = '{8'h01, 8'h40, 8'h55, 8'haa};
        host.spi_frame(1'b1, tx, 4, rx);
        chk("refused frame output", 16'h0000, {rx[2], rx[3]});
        chk("no extra write", 16'h0000, 16'(wlog.size()));
        chk("no extra read", 16'h0000, 16'(rlog.size()));
        $display("test serial done");
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = i[7:0] ^ 8'h96;
        end
        repeat (10) @(posedge clk);
        #10;
        chk("drive in reset", 16'h0000, {bus_oe, 7'h00, req.wr | req.rd});
        rst = 1'b0;
        t_parallel();
        t_deselect();
        t_serial();
        finish_test();
    end
endmodule
